/* File: rtl/adc_scan_queue_sequencer.sv */
// Channel-gain queue sequencer with AXI4-Lite registers and status LED.
// Assumes front end, host link flags and bus share aclk; trigger is async.
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/100ps
module adc_scan_queue_sequencer #(
  parameter int unsigned FAST_HALF_CYC = acq_pkg::FAST_HALF_CYC_DEF,
  parameter int unsigned SLOW_HALF_CYC = acq_pkg::SLOW_HALF_CYC_DEF
)(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [acq_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [acq_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [acq_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [acq_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Host link state
  input wire logic host_attached,
  input wire logic host_first_contact,
  input wire logic xfer_active,
  // External trigger pin
  input wire logic external_trigger_input,
  // Analog front end
  output logic adc_start,
  output logic [2:0] adc_channel,
  output logic [2:0] adc_range,
  output logic adc_diff,
  input wire logic adc_done,
  input wire logic [acq_pkg::CODE_W-1:0] adc_code,
  input wire logic adc_overrange,
  // Sample stream
  output logic sample_valid,
  output logic [acq_pkg::CODE_W-1:0] sample_code,
  output logic [2:0] sample_channel,
  // Status LED
  output logic status_led
);
  import acq_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_WAIT_TRIG, ST_SETUP, ST_FIRE,
                            ST_CONV} scan_state_e;

  scan_state_e state_q;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic aw_full_q, w_full_q;
  logic [1:0] bresp_q, rresp_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q, rdata_q;
  logic [3:0] w_strb_q;
  logic queue_en_q, diff_q, ext_q, trig_hi_q;
  logic [2:0] qlast_q, single_ch_q, single_rng_q, ptr_q;
  logic [2:0] qch_q [QDEPTH];
  logic [2:0] qrng_q [QDEPTH];
  logic [15:0] target_q, done_cnt_q;
  logic done_flag_q;
  logic adc_start_q, adc_diff_q, sample_valid_q;
  logic [2:0] adc_channel_q, adc_range_q, sample_ch_q;
  logic [11:0] sample_code_q;
  logic trig_meta_q, trig_sync_q, trig_act_prev_q;
  logic [2:0] b3_cnt_q;
  logic status_led_q;

  // Write and read channel handshake
  wire aw_take = awvalid && awready_q;
  wire w_take = wvalid && wready_q;
  wire do_write = aw_full_q && w_full_q && !bvalid_q;
  wire aw_full_d = aw_full_q ? !do_write : aw_take;
  wire w_full_d = w_full_q ? !do_write : w_take;
  wire bvalid_d = bvalid_q ? !bready : do_write;
  wire ar_take = arvalid && arready_q;
  wire rvalid_d = rvalid_q ? !rready : ar_take;

  // Write address decode
  wire [5:0] wa = aw_addr_q[7:2];
  wire wr_ctrl = wa == CTRL_OFS[7:2];
  wire wr_qlast = wa == QLAST_OFS[7:2];
  wire wr_single = wa == SINGLE_OFS[7:2];
  wire wr_count = wa == COUNT_OFS[7:2];
  wire wr_queue = wa[5:3] == QUEUE_OFS[7:5];
  wire wr_ro = (wa == STATUS_OFS[7:2]) || (wa == RESULT_OFS[7:2]);
  wire wr_hit = wr_ctrl || wr_qlast || wr_single || wr_count || wr_queue ||
                wr_ro;
  wire lo_wr = do_write && w_strb_q[0];
  wire sw_start = lo_wr && wr_ctrl && w_data_q[CTRL_START];

  // Read address decode and data selection
  wire [5:0] ra = araddr[7:2];
  wire rd_queue = ra[5:3] == QUEUE_OFS[7:5];
  wire [31:0] entry_word = 32'({qrng_q[ra[2:0]], 1'b0, qch_q[ra[2:0]]});
  wire [31:0] ctrl_word = 32'({trig_hi_q, ext_q, diff_q, queue_en_q, 1'b0});
  wire busy = state_q != ST_IDLE;
  wire armed = state_q == ST_WAIT_TRIG;
  wire [31:0] status_word = (32'(done_cnt_q) << ST_CNT_LSB) |
                            (32'(ptr_q) << ST_PTR_LSB) |
                            (32'(done_flag_q) << ST_DONE) |
                            (32'(armed) << ST_ARMED) | 32'(busy);
  wire [31:0] result_word = (32'(sample_ch_q) << RES_CH_LSB) |
                            32'(sample_code_q);
  wire rd_hit = rd_queue || ra == CTRL_OFS[7:2] || ra == QLAST_OFS[7:2] ||
                ra == SINGLE_OFS[7:2] || ra == COUNT_OFS[7:2] ||
                ra == STATUS_OFS[7:2] || ra == RESULT_OFS[7:2];
  wire [31:0] rd_word =
    rd_queue ? entry_word :
    ra == CTRL_OFS[7:2] ? ctrl_word :
    ra == QLAST_OFS[7:2] ? 32'(qlast_q) :
    ra == SINGLE_OFS[7:2] ? 32'({single_rng_q, 1'b0, single_ch_q}) :
    ra == COUNT_OFS[7:2] ? 32'(target_q) :
    ra == STATUS_OFS[7:2] ? status_word :
    ra == RESULT_OFS[7:2] ? result_word : 32'h0;

  // Bus handshake and answer registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      arready_q <= 1'b1;
      bresp_q <= RESP_OKAY;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0;
    end
    else
    begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      bvalid_q <= bvalid_d;
      rvalid_q <= rvalid_d;
      awready_q <= !aw_full_d && !bvalid_d;
      wready_q <= !w_full_d && !bvalid_d;
      arready_q <= !rvalid_d;
      if (do_write)
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR; // Unmapped: error
      if (ar_take)
      begin
        rdata_q <= rd_word;
        rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Capture address and data as each channel is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_addr_q <= 8'h0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
    end
    else
    begin
      if (aw_take)
        aw_addr_q <= awaddr;
      if (w_take)
      begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
    end
  end

  // Configuration registers and queue memory
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {trig_hi_q, ext_q, diff_q, queue_en_q} <= CTRL_RST;
      qlast_q <= 3'h0;
      single_ch_q <= 3'h0;
      single_rng_q <= RANGE_BIPOLAR_TEN_VOLT_RANGE;
      target_q <= 16'h0;
      for (int i = 0; i < QDEPTH; i++)
      begin
        qch_q[i] <= 3'h0;
        qrng_q[i] <= RANGE_BIPOLAR_TEN_VOLT_RANGE;
      end
    end
    else
    begin
      if (lo_wr && wr_ctrl)
        {trig_hi_q, ext_q, diff_q, queue_en_q} <= w_data_q[4:1];
      if (lo_wr && wr_qlast)
        qlast_q <= w_data_q[2:0];
      if (lo_wr && wr_single)
      begin
        single_ch_q <= w_data_q[ENT_CH_LSB +: 3];
        single_rng_q <= w_data_q[ENT_RNG_LSB +: 3];
      end
      if (lo_wr && wr_count)
        target_q[7:0] <= w_data_q[7:0];
      if (do_write && w_strb_q[1] && wr_count)
        target_q[15:8] <= w_data_q[15:8];
      if (lo_wr && wr_queue)
      begin
        qch_q[wa[2:0]] <= w_data_q[ENT_CH_LSB +: 3];
        qrng_q[wa[2:0]] <= w_data_q[ENT_RNG_LSB +: 3];
      end
    end
  end

  // Trigger synchroniser and active-edge detect
  wire trig_act = trig_hi_q ? trig_sync_q : !trig_sync_q;
  wire trig_event = trig_act && !trig_act_prev_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      trig_meta_q <= 1'b0;
      trig_sync_q <= 1'b0;
      trig_act_prev_q <= 1'b1;
    end
    else
    begin
      trig_meta_q <= external_trigger_input;
      trig_sync_q <= trig_meta_q;
      trig_act_prev_q <= trig_act;
    end
  end

  // Current entry, then mode-dependent channel, range and result code
  wire [2:0] cur_ch = queue_en_q ? qch_q[ptr_q] : single_ch_q;
  wire [2:0] cur_rng = queue_en_q ? qrng_q[ptr_q] : single_rng_q;
  wire [2:0] eff_ch = diff_q ? {1'b0, cur_ch[1:0]} : cur_ch;
  wire [2:0] eff_rng = diff_q ? cur_rng : RANGE_BIPOLAR_TEN_VOLT_RANGE;
  wire [11:0] se_code = adc_overrange ? FS_SE : {1'b0, adc_code[11:1]};
  wire [11:0] df_code = adc_overrange ? FS_DIFF : adc_code;
  wire conv_fin = state_q == ST_CONV && adc_done;
  wire last_sample = done_cnt_q + 16'h1 == target_q;
  wire start_ok = sw_start && target_q != 16'h0 && !busy;
  wire wrap = !queue_en_q || ptr_q >= qlast_q;

  // Scan sequencer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= ST_IDLE;
      ptr_q <= 3'h0;
      done_cnt_q <= 16'h0;
      done_flag_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
          if (start_ok)
          begin
            ptr_q <= 3'h0;
            done_cnt_q <= 16'h0;
            done_flag_q <= 1'b0;
            state_q <= w_data_q[CTRL_EXT] ? ST_WAIT_TRIG : ST_SETUP;
          end
        ST_WAIT_TRIG:
          if (trig_event)
            state_q <= ST_SETUP;
        ST_SETUP:
          state_q <= ST_FIRE;
        ST_FIRE:
          state_q <= ST_CONV;
        ST_CONV:
          if (adc_done)
          begin
            done_cnt_q <= done_cnt_q + 16'h1;
            ptr_q <= wrap ? 3'h0 : ptr_q + 3'h1;
            if (last_sample)
            begin
              state_q <= ST_IDLE;
              done_flag_q <= 1'b1;
            end
            else
              state_q <= ST_SETUP;
          end
        default:
          state_q <= ST_IDLE; // Unused codes fall back to idle
      endcase
    end
  end

  // Front-end drive: apply channel and range, then start one cycle later
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      adc_channel_q <= 3'h0;
      adc_range_q <= RANGE_BIPOLAR_TEN_VOLT_RANGE;
      adc_diff_q <= 1'b0;
      adc_start_q <= 1'b0;
    end
    else
    begin
      if (state_q == ST_SETUP)
      begin
        adc_channel_q <= eff_ch;
        adc_range_q <= eff_rng;
        adc_diff_q <= diff_q;
      end
      adc_start_q <= state_q == ST_FIRE;
    end
  end

  // Sample stream out, one pulse per conversion
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sample_valid_q <= 1'b0;
      sample_code_q <= 12'h0;
      sample_ch_q <= 3'h0;
    end
    else
    begin
      sample_valid_q <= conv_fin;
      if (conv_fin)
      begin
        sample_code_q <= adc_diff_q ? df_code : se_code;
        sample_ch_q <= adc_channel_q;
      end
    end
  end

  // LED blink timers, periods set from the clock rate
  logic fast_tick, fast_phase, slow_phase;
  wire b3_act = b3_cnt_q != 3'h0;
  blink_gen #(.HALF(FAST_HALF_CYC)) u_fast_blink (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(xfer_active || b3_act),
    .tick(fast_tick),
    .phase(fast_phase)
  );
  blink_gen #(.HALF(SLOW_HALF_CYC)) u_slow_blink (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(armed),
    .tick(),
    .phase(slow_phase)
  );

  // LED priority: armed, first contact, transfer, attached; never disabled
  wire led_d = armed ? slow_phase :
               (b3_act || xfer_active) ? fast_phase :
               host_attached;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      b3_cnt_q <= 3'h0;
      status_led_q <= 1'b0;
    end
    else
    begin
      if (host_first_contact)
        b3_cnt_q <= BLINK3_HALVES;
      else if (b3_act && fast_tick)
        b3_cnt_q <= b3_cnt_q - 3'h1;
      status_led_q <= led_d;
    end
  end

  // Outputs straight from flip-flops
  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign adc_start = adc_start_q;
  assign adc_channel = adc_channel_q;
  assign adc_range = adc_range_q;
  assign adc_diff = adc_diff_q;
  assign sample_valid = sample_valid_q;
  assign sample_code = sample_code_q;
  assign sample_channel = sample_ch_q;
  assign status_led = status_led_q;

  // Checks on sequencing, mode handling and LED
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_setup;
    state_q == ST_SETUP;
  endsequence
  sequence s_fin_wrap;
    conv_fin && queue_en_q && ptr_q >= qlast_q && !last_sample;
  endsequence

  property p_go_entry0;
    state_q == ST_IDLE && start_ok && !w_data_q[CTRL_EXT] |=>
      state_q == ST_SETUP && ptr_q == 3'h0;
  endproperty
  a_go_entry0: assert property (p_go_entry0)
    else $error("scan did not begin at entry zero");

  property p_apply_then_start;
    s_setup |=> adc_channel_q == $past(eff_ch) && !adc_start_q ##1
      adc_start_q && $stable(adc_channel_q);
  endproperty
  a_apply_then_start: assert property (p_apply_then_start)
    else $error("channel not applied before start");

  property p_wrap;
    s_fin_wrap |=> ptr_q == 3'h0 ##1 state_q == ST_FIRE;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("queue pointer did not wrap");

  property p_stop;
    conv_fin && last_sample |=> state_q == ST_IDLE && done_flag_q &&
      done_cnt_q == target_q;
  endproperty
  a_stop: assert property (p_stop)
    else $error("scan did not stop at requested count");

  property p_se_res;
    sample_valid_q && !$past(adc_diff_q) |-> !sample_code_q[11];
  endproperty
  a_se_res: assert property (p_se_res)
    else $error("single-ended result wider than 11 bits");

  property p_diff_ch;
    adc_start_q && adc_diff_q |-> !adc_channel_q[2];
  endproperty
  a_diff_ch: assert property (p_diff_ch)
    else $error("differential channel above three");

  property p_se_rng;
    adc_start_q && !adc_diff_q |-> adc_range_q == RANGE_BIPOLAR_TEN_VOLT_RANGE;
  endproperty
  a_se_rng: assert property (p_se_rng)
    else $error("single-ended range not ten volt");

  property p_ovr;
    conv_fin && adc_overrange && adc_diff_q |=> sample_code_q == FS_DIFF;
  endproperty
  a_ovr: assert property (p_ovr)
    else $error("over-range did not give full scale");

  property p_trig;
    state_q == ST_WAIT_TRIG && trig_event |=> state_q == ST_SETUP ##2
      adc_start_q;
  endproperty
  a_trig: assert property (p_trig)
    else $error("trigger did not start the scan");

  property p_led_arm;
    armed |=> status_led_q == $past(slow_phase);
  endproperty
  a_led_arm: assert property (p_led_arm)
    else $error("LED not slow blinking while armed");
endmodule : adc_scan_queue_sequencer

/* File: rtl/blink_gen.sv */
// Half-period timer for the status LED blink patterns.
// Assumes run comes from logic on the same clock.
`timescale 1ns/100ps
module blink_gen #(
  parameter int unsigned HALF = 4
)(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control and result
  input wire logic run,
  output logic tick,
  output logic phase
);
  localparam int unsigned W = $clog2(HALF + 1);
  logic [W-1:0] cnt_q;
  logic phase_q;

  // Tick at the end of each half period
  assign tick = run && (cnt_q == W'(HALF - 1));
  assign phase = phase_q;

  // Count while running, park off when stopped
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run)
    begin
      cnt_q <= '0;
      phase_q <= 1'b0;
    end
    else
    begin
      cnt_q <= tick ? '0 : cnt_q + W'(1);
      phase_q <= phase_q ^ tick;
    end
  end
endmodule : blink_gen

/* File: shared/acq_pkg.sv */
// Constants shared by the acquisition sequencer and its blink timer.
// Assumes a 20 MHz system clock and an 8-bit AXI4-Lite byte address.
package acq_pkg;
  // Clock and LED timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned FAST_HALF_MS = 100;
  localparam int unsigned SLOW_HALF_MS = 500;
  localparam int unsigned FAST_HALF_CYC_DEF = CLK_HZ / 1000 * FAST_HALF_MS;
  localparam int unsigned SLOW_HALF_CYC_DEF = CLK_HZ / 1000 * SLOW_HALF_MS;
  localparam logic [2:0] BLINK3_HALVES = 3'h6;
  // Bus and count widths, queue depth
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CODE_W = 12;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned QDEPTH = 8;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] QLAST_OFS = 8'h04;
  localparam logic [7:0] SINGLE_OFS = 8'h08;
  localparam logic [7:0] COUNT_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] RESULT_OFS = 8'h14;
  localparam logic [7:0] QUEUE_OFS = 8'h20;
  // Control fields
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_QEN = 1;
  localparam int unsigned CTRL_DIFF = 2;
  localparam int unsigned CTRL_EXT = 3;
  localparam int unsigned CTRL_TRIG_HI = 4;
  // Entry fields: channel in [2:0], range in [6:4]
  localparam int unsigned ENT_CH_LSB = 0;
  localparam int unsigned ENT_RNG_LSB = 4;
  // Status and result fields
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_ARMED = 1;
  localparam int unsigned ST_DONE = 2;
  localparam int unsigned ST_PTR_LSB = 4;
  localparam int unsigned ST_CNT_LSB = 16;
  localparam int unsigned RES_CH_LSB = 12;
  // Range codes, index 1 is the fixed bipolar ten volt range
  localparam logic [2:0] RANGE_BIPOLAR_TEN_VOLT_RANGE = 3'h1;
  // Full-scale codes, bus answers and control reset value
  localparam logic [11:0] FS_DIFF = 12'hfff;
  localparam logic [11:0] FS_SE = 12'h7ff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] CTRL_RST = 4'h0;
endpackage : acq_pkg

/* File: tb/adc_scan_queue_sequencer_bench.sv */
// Self-checking bench for the channel-gain queue sequencer.
// Assumes the front end model beside it and short blink parameters.
`timescale 1ns/100ps
module adc_scan_queue_sequencer_bench;
  import acq_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic host_attached, host_first_contact, xfer_active, trig, slow, m_ovr;
  logic awready, wready, bvalid, arready, rvalid, adc_start, adc_diff;
  logic adc_done, adc_overrange, sample_valid, status_led, m_qen, m_diff;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, d;
  logic [2:0] adc_channel, adc_range, sample_channel, e_ch[8], e_rg[8];
  logic [11:0] adc_code, sample_code;
  int fail_count, total_checks, nent, idx, k, i, t;

  adc_scan_queue_sequencer #(.FAST_HALF_CYC(4), .SLOW_HALF_CYC(8)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .host_attached(host_attached), .host_first_contact(host_first_contact),
    .xfer_active(xfer_active), .external_trigger_input(trig),
    .adc_start(adc_start), .adc_channel(adc_channel),
    .adc_range(adc_range), .adc_diff(adc_diff), .adc_done(adc_done),
    .adc_code(adc_code), .adc_overrange(adc_overrange),
    .sample_valid(sample_valid), .sample_code(sample_code),
    .sample_channel(sample_channel), .status_led(status_led));

  front_end_model u_fe (
    .aclk(aclk), .aresetn(aresetn), .adc_start(adc_start),
    .adc_channel(adc_channel), .adc_range(adc_range), .adc_diff(adc_diff),
    .slow(slow), .over(m_ovr), .adc_done(adc_done), .adc_code(adc_code),
    .adc_overrange(adc_overrange));

  // Clock, 50 ns period
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Bus write; bready stays high so the answer is taken when it comes
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] er);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    // Wait for the answer however long it takes; the watchdog ends a hang
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    chk(32'(bresp), 32'(er));
  endtask : wr

  // Bus read; data and response taken at the rvalid edge
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    v = rdata;
    rsp = rresp;
  endtask : rd

  task automatic count_toggles(input int n, output int c);
    logic last;
    c = 0;
    last = status_led;
    repeat (n)
    begin
      @(negedge aclk);
      if (status_led !== last) c++;
      last = status_led;
    end
    @(posedge aclk); // Hand back just after a rising edge
  endtask : count_toggles

  // Expected channel and code for one sample of a given entry
  function automatic logic [14:0] expect_smp(input logic [2:0] ch,
      input logic [2:0] rg, input logic df, input logic ov);
    logic [11:0] raw;
    raw = {1'b1, df ? rg : RANGE_BIPOLAR_TEN_VOLT_RANGE, ch, df, 4'ha};
    if (df) return {ch, ov ? FS_DIFF : raw};
    return {ch, ov ? FS_SE : {1'b0, raw[11:1]}};
  endfunction : expect_smp

  // Each delivered sample against the entry it should have used
  always @(negedge aclk)
    if (sample_valid === 1'b1)
    begin
      k = m_qen ? idx % nent : 0;
      chk(32'({sample_channel, sample_code}),
          32'(expect_smp(e_ch[k], e_rg[k], m_diff, m_ovr)));
      idx++;
    end

  // Load queue and count, start, optionally via trigger, wait for done
  task automatic run_scan(input logic qen, input logic df, input int n,
      input int cnt, input logic ov, input logic ext, input logic hi);
    logic [31:0] v;
    int j;
    m_qen = qen;
    m_diff = df;
    m_ovr = ov;
    nent = n;
    idx = 0;
    slow <= 1'($urandom);
    trig <= !hi;
    for (j = 0; j < 8; j++)
    begin
      e_ch[j] = 3'($urandom) & (df ? 3'h3 : 3'h7);
      e_rg[j] = 3'($urandom);
      wr(QUEUE_OFS + 8'(4 * j),
         {25'h0, e_rg[j], 1'b0, e_ch[j] ^ 3'(!qen)}, RESP_OKAY);
    end
    wr(SINGLE_OFS, {25'h0, e_rg[0], 1'b0, e_ch[0]}, RESP_OKAY);
    wr(QLAST_OFS, 32'(n - 1), RESP_OKAY);
    wr(COUNT_OFS, 32'(cnt), RESP_OKAY);
    wr(CTRL_OFS, {27'h0, hi, ext, df, qen, 1'b1}, RESP_OKAY);
    if (ext)
    begin
      count_toggles(40, t);
      chk(32'(idx), 32'h0);
      chk(32'(t >= 4 && t <= 6), 32'h1);
      rd(STATUS_OFS, v);
      chk(32'(v[ST_ARMED]), 32'h1);
      trig <= hi;
    end
    v = 32'h0;
    for (j = 0; j < 3000 && v[ST_DONE] !== 1'b1; j++)
      rd(STATUS_OFS, v);
    repeat (20) @(posedge aclk);
    chk(32'(idx), 32'(cnt));
    rd(STATUS_OFS, v);
    d = (32'(cnt) << ST_CNT_LSB) | (32'h1 << ST_DONE) |
        (32'(qen ? cnt % n : 0) << ST_PTR_LSB);
    chk(v, d);
    // Result holds the last sample, then queue and control read back
    j = qen ? (cnt - 1) % n : 0;
    rd(RESULT_OFS, v);
    chk(v, 32'(expect_smp(e_ch[j], e_rg[j], df, ov)));
    rd(QUEUE_OFS, v);
    chk(v, {25'h0, e_rg[0], 1'b0, e_ch[0] ^ 3'(!qen)});
    rd(CTRL_OFS, v);
    chk(v, {27'h0, hi, ext, df, qen, 1'b0});
    if (ext) chk(32'(status_led), 32'h1);
  endtask : run_scan

  // Hang guard, about ten times the expected run length
  initial
  begin
    #(50 * 20000);
    fail_count++;
    $display("Error at %0t: run did not finish", $time);
    stop_test();
  end

  // Main sequence
  initial
  begin
    {aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
    {host_attached, host_first_contact, xfer_active, trig, slow} = '0;
    {m_ovr, m_qen, m_diff, nent, idx, fail_count, total_checks} = '0;
    bready = 1'b1;
    rready = 1'b1;
    wstrb = 4'hf;
    void'($urandom(32'h5cdbc4d0));
    repeat (16) @(posedge aclk);
    chk(32'({adc_start, adc_range, status_led}), 32'h2);
    aresetn <= 1'b1;
    host_attached <= 1'b1;
    repeat (2) @(posedge aclk);
    count_toggles(20, t);
    chk(32'({t[7:0], status_led}), 32'h1);
    wr(8'h40, 32'h1, RESP_SLVERR);
    rd(8'h40, d);
    chk({d[29:0], rsp}, {30'h0, RESP_SLVERR});
    xfer_active <= 1'b1;
    count_toggles(40, t);
    chk(32'(t >= 9 && t <= 11), 32'h1);
    xfer_active <= 1'b0;
    repeat (10) @(posedge aclk);
    host_first_contact <= 1'b1;
    @(posedge aclk);
    host_first_contact <= 1'b0;
    count_toggles(40, t);
    chk(32'({t[7:0], status_led}), 32'hd);
    run_scan(1'b1, 1'b0, 8, 17, 1'b0, 1'b0, 1'b1);
    run_scan(1'b1, 1'b1, 1, 3, 1'b0, 1'b0, 1'b1);
    run_scan(1'b0, 1'b0, 1, 4, 1'b0, 1'b0, 1'b1);
    run_scan(1'b1, 1'b1, 3, 5, 1'b1, 1'b0, 1'b1);
    run_scan(1'b1, 1'b0, 2, 3, 1'b1, 1'b0, 1'b1);
    run_scan(1'b1, 1'b1, 4, 6, 1'b0, 1'b1, 1'b1);
    run_scan(1'b1, 1'b0, 4, 6, 1'b0, 1'b1, 1'b0);
    for (i = 0; i < 6; i++)
      run_scan(1'b1, 1'($urandom), int'(1 + $urandom % 8),
               int'(1 + $urandom % 20), 1'b0, 1'b0, 1'b1);
    stop_test();
  end
endmodule : adc_scan_queue_sequencer_bench

/* File: tb/front_end_model.sv */
// Behavioural analog front end that answers conversion requests.
// Assumes the sequencer's front-end outputs are synchronous to aclk.
`timescale 1ns/100ps
module front_end_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Requests from the sequencer
  input wire logic adc_start,
  input wire logic [2:0] adc_channel,
  input wire logic [2:0] adc_range,
  input wire logic adc_diff,
  // Bench controls: slow answer, over-range input
  input wire logic slow,
  input wire logic over,
  // Answers
  output logic adc_done,
  output logic [11:0] adc_code,
  output logic adc_overrange
);
  logic [2:0] wait_q;

  // Code carries the applied setup, so a wrong channel or range shows
  always_ff @(posedge aclk)
  begin
    adc_done <= 1'b0;
    adc_code <= ~adc_code; // Meaningless outside the done pulse
    adc_overrange <= ~adc_overrange;
    if (!aresetn)
    begin
      wait_q <= 3'h0;
      adc_code <= 12'h5a5;
      adc_overrange <= 1'b0;
    end
    else if (adc_start)
      wait_q <= slow ? 3'h5 : 3'h1;
    else if (wait_q != 3'h0)
    begin
      wait_q <= wait_q - 3'h1;
      if (wait_q == 3'h1)
      begin
        adc_done <= 1'b1;
        adc_code <= {1'b1, adc_range, adc_channel, adc_diff, 4'ha};
        adc_overrange <= over;
      end
    end
  end
endmodule : front_end_model
